// ---- verilog/amp_ctrl_regs.svh ----
// Behaviour
// - Multi-byte read streams successive register bytes.
// - Three-bit slew select, reset code 100.
// - Current sense range at bits 2:1.
// - Sense mute bit 1 mutes current sense.
// - Sense mute bit 0 mutes voltage sense.
// - Power bit 1 powers down current sense.
// - Power bit 0 powers down voltage sense.
// - Powered-down sense channel returns null samples.
// - No attenuation below limit, attack above it.
// - Gain reduction decays only past hysteresis margin.
// - Limit constant above inflection, sloped below.
// - Attack, decay, inflection, slope are configurable.
// - Boost forced on below 2.9 V battery.
// - Shut down at brownout level, never below 2.7 V.
// - Look-ahead enables boost before output nears battery.
// - Unneeded boost is disabled and bypassed.
// - Amp control bit 4 selects boost mode.
`ifndef AMP_CTRL_REGS_SVH
`define AMP_CTRL_REGS_SVH

// Register offsets on the control port.
`define REG_SLEW 8'h00
`define REG_SENSE_CFG 8'h01
`define REG_SENSE_MUTE 8'h02
`define REG_POWER2 8'h03
`define REG_AMP_CTRL 8'h04
`define REG_VLIM_MAX 8'h05
`define REG_INFLECTION 8'h06
`define REG_SLOPE 8'h07
`define REG_HYST 8'h08
`define REG_ATTACK 8'h09
`define REG_DECAY 8'h0a
`define REG_BROWNOUT 8'h0b
`define REG_STATUS 8'h0c
`define REG_ATTEN 8'h0d

// Field positions.
`define BIT_BOOST_MODE 4
`define BIT_ISNS 1
`define BIT_VSNS 0

// Reset values.
`define RST_SLEW 3'h4
`define RST_RANGE 2'h0
`define RST_BOOST_MODE 1'h1
`define RST_VLIM_MAX 8'hc0
`define RST_INFLECTION 8'h64
`define RST_SLOPE 8'h10
`define RST_HYST 8'h08
`define RST_ATTACK 8'h01
`define RST_DECAY 8'h40
`define RST_BROWNOUT 8'h00

// Device address upper five bits on the two-wire port.
`define DEV_ADDR_HI 5'h13

// Battery thresholds in millivolts and the code step of level registers.
`define BOOST_FORCE_MV 16'h0b54
`define BROWNOUT_MIN_MV 16'h0a8c
`define LEVEL_STEP_MV 16'h000a

`endif

// ---- verilog/amp_ctrl_pkg.sv ----
package amp_ctrl_pkg;

  // Two-wire slave sequencing states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RDATA_ACK = 4'b1000
  } i2c_state_t;

  // Magnitude of a signed sample; the most negative value saturates.
  function automatic logic [14:0] magnitude(input logic signed [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : 16'(s);
    magnitude = m[15] ? 15'h7fff : m[14:0];
  endfunction

  // Battery level code to millivolts, floor at 2.7 V.
  function automatic logic [15:0] code_to_mv(input logic [7:0] code);
    code_to_mv = 16'h0a8c + 16'(code) * 16'h000a;
  endfunction

endpackage

// ---- verilog/agc_limiter.sv ----
`timescale 1ns/1ps
module agc_limiter
  import amp_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Audio in.
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_sample,
  input wire logic [15:0] i_vbat_mv,
  // Tuning.
  input wire logic [7:0] i_vlim_max,
  input wire logic [7:0] i_inflection,
  input wire logic [7:0] i_slope,
  input wire logic [7:0] i_hyst,
  input wire logic [7:0] i_attack,
  input wire logic [7:0] i_decay,
  // Audio out and state.
  output logic signed [15:0] o_sample,
  output logic [7:0] o_atten
);

  logic [15:0] infl_mv; // Inflection point in millivolts.
  logic [14:0] vmax; // Flat part of the limit.
  logic [23:0] drop; // Limit reduction below inflection.
  logic [14:0] limit; // Current output limit.
  logic signed [25:0] prod; // Sample times gain.
  logic signed [15:0] scaled; // Attenuated sample.
  logic [14:0] mag; // Magnitude after attenuation.
  logic [7:0] atk_cnt_q; // Samples since the last attack step.
  logic [7:0] dcy_cnt_q; // Samples since the last decay step.

  // Limit follows battery below inflection, stays flat above it.
  always_comb begin
    infl_mv = code_to_mv(i_inflection);
    vmax = {i_vlim_max, 7'h00};
    drop = 24'h0;
    limit = vmax;
    if (i_vbat_mv < infl_mv) begin
      drop = (24'(infl_mv - i_vbat_mv) * 24'(i_slope)) >> 4;
      limit = (drop >= 24'(vmax)) ? 15'h0 : vmax - drop[14:0];
    end
  end

  // Gain is 256 minus attenuation, in 1/256 steps.
  always_comb begin
    prod = i_sample * $signed({1'b0, 9'h100 - 9'(o_atten)});
    scaled = prod[23:8];
    mag = magnitude(scaled);
  end

  // Attack above the limit, decay only below limit less hysteresis.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_atten <= 8'h00;
      atk_cnt_q <= 8'h00;
      dcy_cnt_q <= 8'h00;
    end else if (i_sample_valid) begin
      if (mag > limit) begin
        dcy_cnt_q <= 8'h00;
        if (atk_cnt_q >= i_attack) begin
          atk_cnt_q <= 8'h00;
          if (o_atten != 8'hff) begin
            o_atten <= o_atten + 8'h01;
          end
        end else begin
          atk_cnt_q <= atk_cnt_q + 8'h01;
        end
      end else if (16'(mag) + 16'(i_hyst) < 16'(limit)) begin
        atk_cnt_q <= 8'h00;
        if (dcy_cnt_q >= i_decay) begin
          dcy_cnt_q <= 8'h00;
          if (o_atten != 8'h00) begin
            o_atten <= o_atten - 8'h01;
          end
        end else begin
          dcy_cnt_q <= dcy_cnt_q + 8'h01;
        end
      end else begin
        // Inside the hysteresis band the gain simply holds.
        atk_cnt_q <= 8'h00;
        dcy_cnt_q <= 8'h00;
      end
    end
  end

  // Registered audio output.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sample <= 16'sh0000;
    end else if (i_sample_valid) begin
      o_sample <= scaled;
    end
  end

endmodule // agc_limiter

// ---- verilog/boost_lookahead.sv ----
`timescale 1ns/1ps
`include "amp_ctrl_regs.svh"
module boost_lookahead
  import amp_ctrl_pkg::*;
#(
  parameter logic [15:0] FS_MV = 16'h1f40,
  parameter logic [15:0] HEADROOM_MV = 16'h0190,
  parameter logic [15:0] HOLD_SAMPLES = 16'h0100,
  parameter int STEP_SHIFT = 7
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Upcoming audio and battery.
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_sample,
  input wire logic [15:0] i_vbat_mv,
  input wire logic i_mode,
  // Boost command.
  output logic o_enable,
  output logic o_bypass,
  output logic [3:0] o_level
);

  logic [30:0] req_full; // Required output in scaled millivolts.
  logic [16:0] need_mv; // Required rail with headroom.
  logic need; // Audio demand exceeds battery.
  logic force_on; // Battery below the forced-boost level.
  logic [16:0] excess; // Rail needed above battery.
  logic [16:0] steps; // Excess in level steps.
  logic [15:0] hold_q; // Samples left before the boost may drop.

  // Demand is judged on the sample before gain, giving look-ahead.
  always_comb begin
    req_full = 31'(magnitude(i_sample)) * 31'(FS_MV);
    need_mv = 17'(req_full[30:15]) + 17'(HEADROOM_MV);
    need = need_mv >= 17'(i_vbat_mv);
    force_on = i_vbat_mv < `BOOST_FORCE_MV;
    excess = need ? need_mv - 17'(i_vbat_mv) : 17'h0;
    steps = excess >> STEP_SHIFT;
  end

  // Enable, level and bypass; the hold timer avoids chattering.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_enable <= 1'b0;
      o_bypass <= 1'b1;
      o_level <= 4'h0;
      hold_q <= 16'h0000;
    end else if (i_sample_valid) begin
      if (need || force_on) begin
        o_enable <= 1'b1;
        o_bypass <= 1'b0;
        hold_q <= HOLD_SAMPLES;
        if (i_mode) begin
          o_level <= 4'hf;
        end else begin
          o_level <= (steps >= 17'h0f) ? 4'hf : 4'(steps) + 4'h1;
        end
      end else if (hold_q != 16'h0000) begin
        hold_q <= hold_q - 16'h0001;
      end else begin
        o_enable <= 1'b0;
        o_bypass <= 1'b1;
        o_level <= 4'h0;
      end
    end
  end

endmodule // boost_lookahead

// ---- verilog/speaker_amp_sense_boost_control.sv ----
`timescale 1ns/1ps
`include "amp_ctrl_regs.svh"
module speaker_amp_sense_boost_control
  import amp_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Two-wire control port and address straps.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_adr0,
  input wire logic i_adr1,
  // Battery monitor.
  input wire logic i_vbat_valid,
  input wire logic [15:0] i_vbat_mv,
  // Audio path.
  input wire logic i_audio_valid,
  input wire logic signed [15:0] i_audio,
  output logic o_audio_valid,
  output logic signed [15:0] o_audio,
  // Sense samples.
  input wire logic i_sense_valid,
  input wire logic signed [15:0] i_isense,
  input wire logic signed [15:0] i_vsense,
  output logic o_sense_valid,
  output logic signed [15:0] o_isense,
  output logic signed [15:0] o_vsense,
  // Analog controls.
  output logic [2:0] o_slew_select,
  output logic [1:0] o_current_sense_range,
  output logic o_current_sense_powerdown,
  output logic o_voltage_sense_powerdown,
  output logic o_boost_mode_select,
  output logic o_boost_enable,
  output logic o_boost_bypass,
  output logic [3:0] o_boost_level,
  output logic o_shutdown
);

  // Pin synchronisers; stage one only feeds stage two.
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [1:0] adr_s1_q, adr_s2_q;
  // Bus events from the synchronised pins.
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] dev_addr;
  // Slave sequencing.
  i2c_state_t state_q;
  logic [7:0] shreg_q; // Shift register for both directions.
  logic [3:0] cnt_q; // Bits moved in the current byte.
  logic rw_q; // Direction of the current access.
  logic [7:0] ptr_q; // Register pointer, auto-incrementing.
  logic wr_stb_q; // One-cycle write strobe into the register file.
  logic [7:0] wr_addr_q, wr_data_q;
  logic [7:0] rd_data; // Read mux output.
  // Register file contents.
  logic [2:0] slew_q;
  logic [1:0] range_q;
  logic isns_mute_q, vsns_mute_q;
  logic isns_pd_q, vsns_pd_q;
  logic boost_mode_q;
  logic [7:0] vlim_max_q, inflection_q, slope_q, hyst_q, attack_q, decay_q, brownout_q;
  // Processing state.
  logic [15:0] vbat_q; // Last battery reading.
  logic [7:0] atten;
  logic signed [15:0] agc_sample;
  logic audio_valid_q;

  // Two flip-flops on every pin, a third on clock and data for edge detection.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      adr_s1_q <= 2'h0;
      adr_s2_q <= 2'h0;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      adr_s1_q <= {i_adr1, i_adr0};
      adr_s2_q <= adr_s1_q;
    end
  end

  // Start and stop are data edges while the clock is high.
  always_comb begin
    scl_rise = scl_s2_q & ~scl_s3_q;
    scl_fall = ~scl_s2_q & scl_s3_q;
    bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    dev_addr = {`DEV_ADDR_HI, adr_s2_q};
  end

  // The line is only ever pulled low; the pull-up gives the high level.
  assign o_sda_out = 1'b0;

  // Read mux; unmapped offsets and reserved bits read as zero.
  always_comb begin
    case (ptr_q)
      `REG_SLEW: rd_data = {5'h00, slew_q};
      `REG_SENSE_CFG: rd_data = {5'h00, range_q, 1'b0};
      `REG_SENSE_MUTE: rd_data = {6'h00, isns_mute_q, vsns_mute_q};
      `REG_POWER2: rd_data = {6'h00, isns_pd_q, vsns_pd_q};
      `REG_AMP_CTRL: rd_data = {3'h0, boost_mode_q, 4'h0};
      `REG_VLIM_MAX: rd_data = vlim_max_q;
      `REG_INFLECTION: rd_data = inflection_q;
      `REG_SLOPE: rd_data = slope_q;
      `REG_HYST: rd_data = hyst_q;
      `REG_ATTACK: rd_data = attack_q;
      `REG_DECAY: rd_data = decay_q;
      `REG_BROWNOUT: rd_data = brownout_q;
      `REG_STATUS: rd_data = {4'h0, o_shutdown, o_boost_bypass, o_boost_enable, 1'b0};
      `REG_ATTEN: rd_data = atten;
      default: rd_data = 8'h00;
    endcase
  end

  // Slave sequencer: bits sampled on clock rise, driven after clock fall.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      shreg_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      o_sda_oe <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (bus_start) begin
        // A repeated start keeps the pointer so a read follows its write.
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                // Another device's address: stay off the bus until the next start.
                if (shreg_q[7:1] == dev_addr) begin
                  rw_q <= shreg_q[0];
                  o_sda_oe <= 1'b1;
                  state_q <= ST_ADDR_ACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_REG) begin
                ptr_q <= shreg_q;
                o_sda_oe <= 1'b1;
                state_q <= ST_REG_ACK;
              end else begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shreg_q;
                ptr_q <= ptr_q + 8'h01;
                o_sda_oe <= 1'b1;
                state_q <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                // Load the byte at the pointer and drive its first bit.
                shreg_q <= rd_data;
                o_sda_oe <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h1;
                state_q <= ST_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                cnt_q <= 4'h0;
                state_q <= ST_REG;
              end
            end
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                o_sda_oe <= 1'b0;
                state_q <= ST_RDATA_ACK;
              end else begin
                o_sda_oe <= ~shreg_q[6];
                shreg_q <= {shreg_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              // Acknowledge asks for another byte; a not-acknowledge ends it.
              state_q <= sda_s2_q ? ST_IDLE : ST_ADDR_ACK;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register file; each register stores only its own fields.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      slew_q <= `RST_SLEW;
      range_q <= `RST_RANGE;
      isns_mute_q <= 1'b0;
      vsns_mute_q <= 1'b0;
      isns_pd_q <= 1'b0;
      vsns_pd_q <= 1'b0;
      boost_mode_q <= `RST_BOOST_MODE;
      vlim_max_q <= `RST_VLIM_MAX;
      inflection_q <= `RST_INFLECTION;
      slope_q <= `RST_SLOPE;
      hyst_q <= `RST_HYST;
      attack_q <= `RST_ATTACK;
      decay_q <= `RST_DECAY;
      brownout_q <= `RST_BROWNOUT;
    end else if (wr_stb_q) begin
      // Reserved codes are stored as written and touch nothing else.
      case (wr_addr_q)
        `REG_SLEW: slew_q <= wr_data_q[2:0];
        `REG_SENSE_CFG: range_q <= wr_data_q[2:1];
        `REG_SENSE_MUTE: begin
          isns_mute_q <= wr_data_q[`BIT_ISNS];
          vsns_mute_q <= wr_data_q[`BIT_VSNS];
        end
        `REG_POWER2: begin
          isns_pd_q <= wr_data_q[`BIT_ISNS];
          vsns_pd_q <= wr_data_q[`BIT_VSNS];
        end
        `REG_AMP_CTRL: boost_mode_q <= wr_data_q[`BIT_BOOST_MODE];
        `REG_VLIM_MAX: vlim_max_q <= wr_data_q;
        `REG_INFLECTION: inflection_q <= wr_data_q;
        `REG_SLOPE: slope_q <= wr_data_q;
        `REG_HYST: hyst_q <= wr_data_q;
        `REG_ATTACK: attack_q <= wr_data_q;
        `REG_DECAY: decay_q <= wr_data_q;
        `REG_BROWNOUT: brownout_q <= wr_data_q;
        default: begin
        end
      endcase
    end
  end

  // Control outputs straight from the register file.
  always_comb begin
    o_slew_select = slew_q;
    o_current_sense_range = range_q;
    o_current_sense_powerdown = isns_pd_q;
    o_voltage_sense_powerdown = vsns_pd_q;
    o_boost_mode_select = boost_mode_q;
  end

  // Sense samples: powered-down or muted channels read as zero.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sense_valid <= 1'b0;
      o_isense <= 16'sh0000;
      o_vsense <= 16'sh0000;
    end else begin
      o_sense_valid <= i_sense_valid;
      if (i_sense_valid) begin
        o_isense <= (isns_pd_q || isns_mute_q) ? 16'sh0000 : i_isense;
        o_vsense <= (vsns_pd_q || vsns_mute_q) ? 16'sh0000 : i_vsense;
      end
    end
  end

  // Battery capture and sticky brownout shutdown; code 0 is 2.7 V.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vbat_q <= 16'hffff;
      o_shutdown <= 1'b0;
    end else if (i_vbat_valid) begin
      vbat_q <= i_vbat_mv;
      if (i_vbat_mv < code_to_mv(brownout_q)) begin
        o_shutdown <= 1'b1;
      end
    end
  end

  // Battery-tracking gain control on the audio path.
  agc_limiter u_agc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_audio_valid),
    .i_sample(i_audio),
    .i_vbat_mv(vbat_q),
    .i_vlim_max(vlim_max_q),
    .i_inflection(inflection_q),
    .i_slope(slope_q),
    .i_hyst(hyst_q),
    .i_attack(attack_q),
    .i_decay(decay_q),
    .o_sample(agc_sample),
    .o_atten(atten)
  );

  // Boost decision looks at the raw input, registered in the same cycle as the amplifier's sample.
  boost_lookahead u_boost (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_audio_valid),
    .i_sample(i_audio),
    .i_vbat_mv(vbat_q),
    .i_mode(boost_mode_q),
    .o_enable(o_boost_enable),
    .o_bypass(o_boost_bypass),
    .o_level(o_boost_level)
  );

  // Audio out is the limiter output, silenced after brownout.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      audio_valid_q <= 1'b0;
    end else begin
      audio_valid_q <= i_audio_valid;
    end
  end

  assign o_audio_valid = audio_valid_q;
  assign o_audio = o_shutdown ? 16'sh0000 : agc_sample;

endmodule // speaker_amp_sense_boost_control

// ---- tb/amp_ctrl_properties.sv ----
`timescale 1ns/1ps
module amp_ctrl_checker (
  // Clock, reset and the inputs that cause responses.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_vbat_valid,
  input wire logic [15:0] i_vbat_mv,
  input wire logic i_audio_valid,
  input wire logic i_sense_valid,
  // Responses of the device.
  input wire logic signed [15:0] o_audio,
  input wire logic o_sense_valid,
  input wire logic signed [15:0] o_isense,
  input wire logic signed [15:0] o_vsense,
  input wire logic [2:0] o_slew_select,
  input wire logic o_current_sense_powerdown,
  input wire logic o_voltage_sense_powerdown,
  input wire logic o_boost_mode_select,
  input wire logic o_boost_enable,
  input wire logic o_boost_bypass,
  input wire logic [3:0] o_boost_level,
  input wire logic o_shutdown
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // The last battery report was under the forced-boost level.
  logic low_q;
  // A report is used from the next cycle on, so this mirrors the device.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      low_q <= 1'b0;
    end else if (i_vbat_valid) begin
      low_q <= i_vbat_mv < 16'h0b54;
    end
  end
  sequence s_sense;
    i_sense_valid;
  endsequence
  sequence s_class_g;
    i_audio_valid && o_boost_mode_select;
  endsequence
  reset_fields_a: assert property ($past(i_sys_rst) |-> o_slew_select == 3'h4 && o_boost_mode_select)
    else $error("fields not at reset values");
  isense_null_a: assert property (s_sense ##0 o_current_sense_powerdown |=> o_isense == 16'h0000)
    else $error("current sense not null");
  vsense_null_a: assert property (s_sense ##0 o_voltage_sense_powerdown |=> o_vsense == 16'h0000)
    else $error("voltage sense not null");
  sense_delay_a: assert property (s_sense |=> o_sense_valid)
    else $error("sense valid missing");
  boost_force_a: assert property (i_audio_valid && low_q && !o_shutdown |=> o_boost_enable && !o_boost_bypass)
    else $error("boost not forced");
  class_g_level_a: assert property (s_class_g |=> !o_boost_enable || o_boost_level == 4'hf)
    else $error("boost level wrong");
  brownout_a: assert property (i_vbat_valid && i_vbat_mv < 16'h0a8c |-> ##[1:4] o_shutdown)
    else $error("no brownout shutdown");
  shutdown_mute_a: assert property (o_shutdown && i_audio_valid |=> o_audio == 16'h0000 && o_shutdown)
    else $error("audio after shutdown");
endmodule // amp_ctrl_checker
bind speaker_amp_sense_boost_control amp_ctrl_checker chk (.*);

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model (
  // Clock that paces the bus phases.
  input wire logic i_clk,
  // Bus lines; data is only ever pulled low.
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  // Quarter bit in system clocks; wide enough for the device's synchronisers.
  localparam int Q = 6;
  // The clock stands high between frames.
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick();
    repeat (Q) @(negedge i_clk);
  endtask
  // Start, or repeated start when the clock is low.
  task automatic start();
    if (!o_scl) begin
      o_sda_oe = 1'b0;
      tick();
      o_scl = 1'b1;
      tick();
    end
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_oe = 1'b0;
    tick();
  endtask
  // Data moves a quarter bit after the fall, so it never looks like a start.
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = !b;
    tick();
    o_scl = 1'b1;
    tick();
    s = i_sda;
    tick();
    o_scl = 1'b0;
    tick();
  endtask
  // One byte plus acknowledge; a high a leaves the line to the device.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, k);
  endtask
endmodule // i2c_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and bookkeeping.
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [31:0] rs = 32'hf3e06e08;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Inputs; the straps select address 0x4d.
  logic i_adr0 = 1'b1;
  logic i_adr1 = 1'b0;
  logic i_vbat_valid = 1'b0;
  logic i_audio_valid = 1'b0;
  logic i_sense_valid = 1'b0;
  logic [15:0] i_vbat_mv = 16'hffff;
  logic signed [15:0] i_audio = 16'h0000;
  logic signed [15:0] i_isense = 16'h0000;
  logic signed [15:0] i_vsense = 16'h0000;
  logic i_scl, h_oe, k;
  logic [7:0] r;
  // Outputs.
  logic o_sda_out, o_sda_oe, o_audio_valid, o_sense_valid, o_current_sense_powerdown;
  logic o_voltage_sense_powerdown, o_boost_mode_select, o_boost_enable, o_boost_bypass, o_shutdown;
  logic signed [15:0] o_audio, o_isense, o_vsense;
  logic [2:0] o_slew_select;
  logic [1:0] o_current_sense_range;
  logic [3:0] o_boost_level;
  // Pulled-up data line.
  wire i_sda = !(h_oe || (o_sda_oe && !o_sda_out));
  // Register mirror, implemented bits, reserved-code corner rounds.
  logic [7:0] m [5] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h10};
  logic [7:0] mk [5] = '{8'h07, 8'h06, 8'h03, 8'h03, 8'h10};
  logic [7:0] cv [2][5] = '{'{8'h00, 8'h06, 8'h02, 8'h01, 8'h00}, '{8'h01, 8'h02, 8'h01, 8'h02, 8'h10}};
  speaker_amp_sense_boost_control dut (.*);
  i2c_host_model host (.i_clk(i_clk), .o_scl(i_scl), .o_sda_oe(h_oe), .i_sda(i_sda));
  always #20 i_clk = ~i_clk;
  // A hang counts as a mismatch.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction
  // A muted or powered-down channel reads as zero.
  function automatic logic [15:0] es(input logic [15:0] x, input logic z);
    return z ? 16'h0000 : x;
  endfunction
  task automatic fields();
    ck("slew", 16'(m[0][2:0]), 16'(o_slew_select));
    ck("range", 16'(m[1][2:1]), 16'(o_current_sense_range));
    ck("ipd", 16'(m[3][1]), 16'(o_current_sense_powerdown));
    ck("vpd", 16'(m[3][0]), 16'(o_voltage_sense_powerdown));
    ck("mode", 16'(m[4][4]), 16'(o_boost_mode_select));
  endtask
  task automatic addr(input logic rw);
    host.start();
    host.xfer({5'h13, i_adr1, i_adr0, rw}, 1'b1, r, k);
    ck("addr ack", 16'h0000, 16'(k));
  endtask
  task automatic wr(input int a, input int n);
    addr(1'b0);
    host.xfer(8'(a), 1'b1, r, k);
    for (int i = a; i < a + n; i++) begin
      host.xfer(m[i], 1'b1, r, k);
      ck("wr ack", 16'h0000, 16'(k));
    end
    host.stop();
  endtask
  task automatic rd(input int a, input int n);
    addr(1'b0);
    host.xfer(8'(a), 1'b1, r, k);
    addr(1'b1);
    for (int i = a; i < a + n; i++) begin
      host.xfer(8'hff, i == a + n - 1, r, k);
      ck("rd data", 16'(m[i] & mk[i]), 16'(r & mk[i]));
    end
    host.stop();
  endtask
  task automatic sense();
    i_isense = rnd();
    i_vsense = rnd();
    i_sense_valid = 1'b1;
    @(negedge i_clk);
    i_sense_valid = 1'b0;
    @(negedge i_clk);
    ck("isense", es(i_isense, m[2][1] | m[3][1]), o_isense);
    ck("vsense", es(i_vsense, m[2][0] | m[3][0]), o_vsense);
  endtask
  task automatic snd(input logic [15:0] x);
    i_audio = x;
    i_audio_valid = 1'b1;
    @(negedge i_clk);
    i_audio_valid = 1'b0;
    ck("avalid", 16'h0001, 16'(o_audio_valid));
    @(negedge i_clk);
  endtask
  // Waits out the shutdown latency.
  task automatic setv(input logic [15:0] v);
    i_vbat_mv = v;
    i_vbat_valid = 1'b1;
    @(negedge i_clk);
    i_vbat_valid = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    fields();
    ck("bypass", 16'h0001, 16'(o_boost_bypass));
    host.start();
    host.xfer(8'h9c, 1'b1, r, k);
    ck("nack", 16'h0001, 16'(k));
    host.stop();
    for (int t = 0; t < 5; t++) begin
      for (int i = 0; i < 5; i++) begin
        m[i] = t < 2 ? cv[t][i] : 8'(rnd());
      end
      wr(0, 5);
      fields();
      rd(0, 5);
      repeat (3) sense();
    end
    m[4] = 8'h10;
    wr(4, 1);
    fields();
    rd(0, 5);
    setv(16'h0fa0);
    repeat (8) begin
      snd(rnd() & 16'h0fff);
      ck("gain", i_audio, o_audio);
    end
    repeat (300) snd(16'h0000);
    ck("idle boost", 16'h0001, 16'({o_boost_enable, o_boost_bypass}));
    snd(16'h7000);
    ck("boost on", 16'h0002, 16'({o_boost_enable, o_boost_bypass}));
    ck("level", 16'h000f, 16'(o_boost_level));
    repeat (8) snd(16'h7000);
    ck("attack", 16'h0001, 16'(o_audio < 16'sh7000));
    setv(16'h0af0);
    repeat (300) snd(16'h0000);
    ck("forced", 16'h0002, 16'({o_boost_enable, o_boost_bypass}));
    setv(16'h0a28);
    snd(16'h0100);
    ck("shutdown", 16'h0001, 16'(o_shutdown));
    ck("muted", 16'h0000, o_audio);
    final_report();
  end
endmodule // tb_top
